// >>> ksn_map.svh
`ifndef KSN_MAP_SVH
`define KSN_MAP_SVH

// Address space: bit 8 set selects the keyboard I/O ports
`define KSN_ADDR_W          9
`define KSN_IDX_SCAN_CFG    9'h066
`define KSN_IDX_NMI_CS      9'h067
`define KSN_IDX_SHADOW      9'h068
`define KSN_IO_DATA_PORT    9'h160
`define KSN_IO_CTRL_PORT    9'h161

// Scan configuration fields
`define KSN_CFG_RATE_LSB    0
`define KSN_CFG_STYLE_BIT   2
`define KSN_CFG_PRIM_BIT    3
`define KSN_CFG_SW_LSB      4
`define KSN_CFG_RESET       8'h00

// NMI control and status fields
`define KSN_NMI_KEY_FLAG    7
`define KSN_NMI_PER_FLAG    6
`define KSN_NMI_CTL_FLAG    5
`define KSN_NMI_KEY_EN      3
`define KSN_NMI_PER_EN      2
`define KSN_NMI_CTL_EN      1
`define KSN_NMI_RESET       8'h00

// Keyboard control port fields
`define KSN_CTRL_CLKGATE    6
`define KSN_CTRL_RESET      8'h00
`define KSN_DATA_RESET      8'h00

// Periodic rates
`define KSN_CLK_HZ          40000000
`define KSN_RATE0_HZ        51
`define KSN_RATE1_HZ        64
`define KSN_RATE2_HZ        85
`define KSN_RATE3_HZ        128
`define KSN_CNT_W           20

`endif

// >>> ksn_pkg.sv
`default_nettype none
`include "ksn_map.svh"
package ksn_pkg;
   typedef logic [7:0] ksn_byte_t;
   typedef logic [`KSN_ADDR_W-1:0] ksn_addr_t;
   typedef logic [23:0] ksn_lines_t;
   typedef enum logic [1:0] {
      KSN_RATE_51  = 2'h0,
      KSN_RATE_64  = 2'h1,
      KSN_RATE_85  = 2'h2,
      KSN_RATE_128 = 2'h3
   } ksn_rate_t;
endpackage : ksn_pkg
`default_nettype wire

// >>> ksn_rate_div.sv
`default_nettype none
module ksn_rate_div #(
   parameter int unsigned CNT_W = 20,
   parameter int unsigned DIV0  = 784313,
   parameter int unsigned DIV1  = 625000,
   parameter int unsigned DIV2  = 470588,
   parameter int unsigned DIV3  = 312500
) (
   input  wire logic              clk,
   input  wire logic              rst_sync_b,
   input  wire logic              run,
   input  wire ksn_pkg::ksn_rate_t sel,
   output logic                   tick
);
   import ksn_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;

   // Last count of each period for the chosen rate, one less than its cycle count
   always_comb begin
      unique case (sel)
         KSN_RATE_51:  limit = CNT_W'(DIV0 - 1);
         KSN_RATE_64:  limit = CNT_W'(DIV1 - 1);
         KSN_RATE_85:  limit = CNT_W'(DIV2 - 1);
         KSN_RATE_128: limit = CNT_W'(DIV3 - 1);
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cnt_q <= '0;
      end else if (!run || cnt_q >= limit) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign tick = run && (cnt_q >= limit);
endmodule : ksn_rate_div
`default_nettype wire

// >>> ksn_top.sv
// Summary of operation
// RULE_01 - Rate select 00/01/10/11 gives periodic NMI at 51/64/85/128 Hz.
// RULE_02 - Rate select matters only while periodic enable bit 2 is set.
// RULE_03 - Periodic NMI runs regardless of scan style; usable as plain tick.
// RULE_04 - With keydown enable, any return line going low sets keydown flag.
// RULE_05 - Keydown flag also set by a rising drive line.
// RULE_06 - Writing bit 7 high clears keydown NMI and its flag.
// RULE_07 - Periodic flag bit 6 high while active; write 1 clears it.
// RULE_08 - Control-write flag bit 5 high while active; write 1 clears it.
// RULE_09 - Keydown enable bit 3 resets to 0; 1 enables keydown NMIs.
// RULE_10 - Scan style picks keydown source: drive lines 1, return lines 0.
// RULE_11 - Lines are levels; NMI holds while keydown persists and enabled.
// RULE_12 - Bit 7 clear is ignored while a keydown condition exists.
// RULE_13 - Software clears keydown enable first, then writes keydown flag.
// RULE_14 - Periodic enable bit 2 resets to 0; 1 gives periodic NMIs.
// RULE_15 - Software clears periodic flag before setting periodic enable.
// RULE_16 - Control enable bit 1: control port bit 6 rising write gives NMI.
// RULE_17 - Primary select 0: port read gives shift value, shadow last write.
// RULE_18 - Primary select 1: port read gives last write, shadow shift value.
// RULE_19 - Style 0 full scan on return lines; style 1 partial on drives.
// RULE_20 - Primary select resets to 0, serial keyboard; 1 selects matrix.
// RULE_21 - NMI request high while any flag active, low once all cleared.
//
// Strobed register access was left to the implementer.
`default_nettype none
`include "ksn_map.svh"
module ksn_top #(
   parameter int unsigned DIV0 = `KSN_CLK_HZ / `KSN_RATE0_HZ,
   parameter int unsigned DIV1 = `KSN_CLK_HZ / `KSN_RATE1_HZ,
   parameter int unsigned DIV2 = `KSN_CLK_HZ / `KSN_RATE2_HZ,
   parameter int unsigned DIV3 = `KSN_CLK_HZ / `KSN_RATE3_HZ
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire ksn_pkg::ksn_addr_t  addr,
   input  wire ksn_pkg::ksn_byte_t  wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output ksn_pkg::ksn_byte_t       rdata,
   input  wire ksn_pkg::ksn_lines_t return_lines,
   input  wire ksn_pkg::ksn_lines_t drive_lines,
   input  wire ksn_pkg::ksn_byte_t  kbd_shift_value,
   output logic                    kbd_clock_gate,
   output logic                    nmi_req
);
   import ksn_pkg::*;

   logic       rst_meta_q;
   logic       rst_sync_b;

   ksn_byte_t  cfg_q;
   logic       keydown_irq_on_q;
   logic       periodic_irq_on_q;
   logic       ctrl_write_irq_on_q;
   logic       key_flag_q;
   logic       periodic_flag_q;
   logic       ctrl_write_flag_q;
   ksn_byte_t  ctrl_port_q;
   ksn_byte_t  data_port_q;
   ksn_lines_t drive_prev_q;
   ksn_byte_t  rdata_q;
   logic       nmi_q;

   ksn_rate_t  scan_rate_sel;
   logic       scan_style;
   logic       matrix_primary_sel;
   logic       wr_cfg;
   logic       wr_nmi;
   logic       wr_shadow;
   logic       wr_data;
   logic       wr_ctrl;
   logic       return_key;
   logic       drive_key;
   logic       keydown_cond;
   logic       periodic_tick;
   logic       ctrl_rise;
   ksn_byte_t  nmi_view;
   ksn_byte_t  shadow_shift_value;
   ksn_byte_t  port_view;
   ksn_byte_t  rdata_d;
   logic       drive_rise;
   logic       drive_high;
   logic       key_set;
   logic       key_clr;
   logic       per_set;
   logic       per_clr;
   logic       ctl_set;
   logic       ctl_clr;
   logic       nmi_any;

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // Address decode
   assign wr_cfg    = wr && (addr == `KSN_IDX_SCAN_CFG);
   assign wr_nmi    = wr && (addr == `KSN_IDX_NMI_CS);
   assign wr_shadow = wr && (addr == `KSN_IDX_SHADOW);
   assign wr_data   = wr && (addr == `KSN_IO_DATA_PORT);
   assign wr_ctrl   = wr && (addr == `KSN_IO_CTRL_PORT);

   // Scan configuration fields
   assign scan_rate_sel      = ksn_rate_t'(cfg_q[`KSN_CFG_RATE_LSB +: 2]);
   assign scan_style         = cfg_q[`KSN_CFG_STYLE_BIT];
   assign matrix_primary_sel = cfg_q[`KSN_CFG_PRIM_BIT];

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cfg_q <= `KSN_CFG_RESET; // [RULE_20]
      end else if (wr_cfg) begin
         cfg_q <= wdata;
      end
   end

   // Keydown enable, bit 3
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         keydown_irq_on_q <= 1'b0; // [RULE_09]
      end else if (wr_nmi) begin
         keydown_irq_on_q <= wdata[`KSN_NMI_KEY_EN]; // [RULE_09]
      end
   end

   // Periodic enable, bit 2
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         periodic_irq_on_q <= 1'b0; // [RULE_14]
      end else if (wr_nmi) begin
         periodic_irq_on_q <= wdata[`KSN_NMI_PER_EN]; // [RULE_14]
      end
   end

   // Control-write enable, bit 1
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ctrl_write_irq_on_q <= 1'b0; // [RULE_16]
      end else if (wr_nmi) begin
         ctrl_write_irq_on_q <= wdata[`KSN_NMI_CTL_EN]; // [RULE_16]
      end
   end

   // Keydown detection on levels
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         drive_prev_q <= '0;
      end else begin
         drive_prev_q <= drive_lines;
      end
   end

   // Any return line pulled low
   assign return_key = ~&return_lines; // [RULE_04]
   // Rising drive line, or a drive line held high
   assign drive_rise = |(drive_lines & ~drive_prev_q); // [RULE_05]
   assign drive_high = |drive_lines; // [RULE_11]
   assign drive_key  = drive_rise | drive_high;
   // Source chosen by scan style
   assign keydown_cond = scan_style ? drive_key   // [RULE_10] [RULE_19]
                                    : return_key;

   // Keydown flag strobes
   assign key_set = keydown_irq_on_q && keydown_cond; // [RULE_04] [RULE_11]
   assign key_clr = wr_nmi && wdata[`KSN_NMI_KEY_FLAG]
                    && !keydown_cond; // [RULE_06] [RULE_12]

   // Keydown flag
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         key_flag_q <= 1'b0;
      end else if (key_set) begin
         // Set holds while the condition persists, and beats the clear
         key_flag_q <= 1'b1; // [RULE_04] [RULE_11] [RULE_12]
      end else if (key_clr) begin
         key_flag_q <= 1'b0; // [RULE_06] [RULE_12] [RULE_13]
      end
   end

   // Periodic source, independent of scan style
   ksn_rate_div #(
      .CNT_W (`KSN_CNT_W),
      .DIV0  (DIV0),
      .DIV1  (DIV1),
      .DIV2  (DIV2),
      .DIV3  (DIV3)
   ) u_rate_div (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .run        (periodic_irq_on_q), // [RULE_02] [RULE_03]
      .sel        (scan_rate_sel),     // [RULE_01]
      .tick       (periodic_tick)
   );

   // Periodic flag strobes
   assign per_set = periodic_tick; // [RULE_14]
   assign per_clr = wr_nmi && wdata[`KSN_NMI_PER_FLAG]; // [RULE_07]

   // Periodic flag, a tick beats the clear
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         periodic_flag_q <= 1'b0;
      end else if (per_set) begin
         periodic_flag_q <= 1'b1; // [RULE_07] [RULE_14] [RULE_15]
      end else if (per_clr) begin
         periodic_flag_q <= 1'b0; // [RULE_07]
      end
   end

   // Keyboard control port and its write trap
   assign ctrl_rise = wr_ctrl && wdata[`KSN_CTRL_CLKGATE]
                      && !ctrl_port_q[`KSN_CTRL_CLKGATE]; // [RULE_16]

   // Stored control port value
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ctrl_port_q <= `KSN_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_port_q <= wdata;
      end
   end

   // Control-write flag strobes
   assign ctl_set = ctrl_write_irq_on_q && ctrl_rise; // [RULE_16]
   assign ctl_clr = wr_nmi && wdata[`KSN_NMI_CTL_FLAG]; // [RULE_08]

   // Control-write flag, a trapped write beats the clear
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ctrl_write_flag_q <= 1'b0;
      end else if (ctl_set) begin
         ctrl_write_flag_q <= 1'b1; // [RULE_16] [RULE_08]
      end else if (ctl_clr) begin
         ctrl_write_flag_q <= 1'b0; // [RULE_08]
      end
   end

   // Last value written to the data port, also reached as the shadow while primary select is 0
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         data_port_q <= `KSN_DATA_RESET;
      end else if (wr_data || (wr_shadow && !matrix_primary_sel)) begin
         data_port_q <= wdata;
      end
   end

   // Port and shadow swap with the primary interface select
   assign port_view = matrix_primary_sel
                      ? data_port_q      // [RULE_18]
                      : kbd_shift_value; // [RULE_17]
   assign shadow_shift_value = matrix_primary_sel
                               ? kbd_shift_value // [RULE_18]
                               : data_port_q;    // [RULE_17]

   // Status view, reserved bits read zero
   always_comb begin
      nmi_view = 8'h00;
      nmi_view[`KSN_NMI_KEY_FLAG] = key_flag_q;
      nmi_view[`KSN_NMI_PER_FLAG] = periodic_flag_q;
      nmi_view[`KSN_NMI_CTL_FLAG] = ctrl_write_flag_q;
      nmi_view[`KSN_NMI_KEY_EN]   = keydown_irq_on_q;
      nmi_view[`KSN_NMI_PER_EN]   = periodic_irq_on_q;
      nmi_view[`KSN_NMI_CTL_EN]   = ctrl_write_irq_on_q;
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      unique case (addr)
         `KSN_IDX_SCAN_CFG: rdata_d = cfg_q;
         `KSN_IDX_NMI_CS:   rdata_d = nmi_view;
         `KSN_IDX_SHADOW:   rdata_d = shadow_shift_value;
         `KSN_IO_DATA_PORT: rdata_d = port_view;
         `KSN_IO_CTRL_PORT: rdata_d = ctrl_port_q;
         default:           rdata_d = 8'h00;
      endcase
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_q <= 8'h00;
      end else if (rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // Combined NMI request, one cycle behind the flags
   assign nmi_any = key_flag_q | periodic_flag_q | ctrl_write_flag_q;

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         nmi_q <= 1'b0;
      end else begin
         nmi_q <= nmi_any; // [RULE_21]
      end
   end

   assign rdata          = rdata_q;
   assign nmi_req        = nmi_q;
   assign kbd_clock_gate = ctrl_port_q[`KSN_CTRL_CLKGATE];
endmodule : ksn_top
`default_nettype wire

// >>> ksn_top_monitor.sv
`default_nettype none
`include "ksn_map.svh"
module ksn_check
   import ksn_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst_b,
   input wire ksn_pkg::ksn_addr_t  addr,
   input wire ksn_pkg::ksn_byte_t  wdata,
   input wire logic                wr,
   input wire logic                rd,
   input wire ksn_pkg::ksn_byte_t  rdata,
   input wire ksn_pkg::ksn_lines_t return_lines,
   input wire ksn_pkg::ksn_lines_t drive_lines,
   input wire ksn_pkg::ksn_byte_t  kbd_shift_value,
   input wire logic                kbd_clock_gate,
   input wire logic                nmi_req
);
   ksn_byte_t  cfg_q;
   logic [2:0] en_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Mirror of the configuration and enable bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= 8'h00;
         en_q  <= 3'h0;
      end else if (wr && addr == `KSN_IDX_SCAN_CFG) begin
         cfg_q <= wdata;
      end else if (wr && addr == `KSN_IDX_NMI_CS) begin
         en_q <= wdata[3:1];
      end
   end
   AST_CFG_RD: assert property (rd && addr == `KSN_IDX_SCAN_CFG
      |=> rdata == cfg_q) else $error("config readback wrong");
   AST_EN_RD: assert property (rd && addr == `KSN_IDX_NMI_CS
      |=> rdata[3:1] == en_q && !rdata[4] && !rdata[0])
      else $error("enable readback wrong");
   AST_PORT_SER: assert property (rd && addr == `KSN_IO_DATA_PORT
      && !cfg_q[3] |=> rdata == $past(kbd_shift_value))
      else $error("data port not shift value");
   AST_SHD_SER: assert property (rd && addr == `KSN_IDX_SHADOW
      && cfg_q[3] |=> rdata == $past(kbd_shift_value))
      else $error("shadow not shift value");
   AST_GATE: assert property (wr && addr == `KSN_IO_CTRL_PORT
      |=> kbd_clock_gate == $past(wdata[6])) else $error("gate wrong");
   AST_CTL_NMI: assert property (wr && addr == `KSN_IO_CTRL_PORT
      && wdata[6] && !kbd_clock_gate && en_q[0] |=> ##1 nmi_req)
      else $error("control write nmi missing");
   AST_KEY_RET: assert property (en_q[2] && !cfg_q[2]
      && !(&return_lines) |=> ##1 nmi_req) else $error("return key missed");
   AST_KEY_DRV: assert property (en_q[2] && cfg_q[2]
      && |drive_lines |=> ##1 nmi_req) else $error("drive key missed");
   AST_NMI_FALL: assert property ($fell(nmi_req)
      |-> $past(wr, 2) && $past(addr, 2) == `KSN_IDX_NMI_CS)
      else $error("nmi dropped without clear write");
endmodule : ksn_check
bind ksn_top ksn_check ksn_check_i (.clk(clk), .rst_b(rst_b), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .return_lines(return_lines), .drive_lines(drive_lines),
   .kbd_shift_value(kbd_shift_value), .kbd_clock_gate(kbd_clock_gate),
   .nmi_req(nmi_req));
`default_nettype wire

// >>> ksn_kbd_model.sv
`default_nettype none
module ksn_kbd_model
   import ksn_pkg::*;
(
   input  wire logic [4:0]          ret_idx,
   input  wire logic                ret_on,
   input  wire logic [4:0]          drv_idx,
   input  wire logic                drv_on,
   input  wire ksn_pkg::ksn_byte_t  sv_in,
   output ksn_pkg::ksn_lines_t      return_lines,
   output ksn_pkg::ksn_lines_t      drive_lines,
   output ksn_pkg::ksn_byte_t       kbd_shift_value
);
   // Idle returns rest at their pull-up, idle drives low
   always_comb begin
      return_lines = '1;
      drive_lines = '0;
      return_lines[ret_idx] = !ret_on;
      drive_lines[drv_idx] = drv_on;
      kbd_shift_value = sv_in;
   end
endmodule : ksn_kbd_model
`default_nettype wire

// >>> ksn_tb.sv
`default_nettype none
`include "ksn_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ksn_pkg::*;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       rv = 1'b0;
   ksn_addr_t  addr = '0;
   ksn_byte_t  wdata = '0;
   ksn_byte_t  sv = '0;
   ksn_byte_t  rdata;
   ksn_lines_t rl;
   ksn_lines_t dl;
   ksn_byte_t  kv;
   logic [4:0] ki = '0;
   logic       ron = 1'b0;
   logic       don = 1'b0;
   logic       gate;
   logic       nmi;
   ksn_byte_t  q[$];
   int         n_mismatch = 0;
   int         cmp_count = 0;
   always #12.5 clk = ~clk;
   ksn_top #(.DIV0(40), .DIV1(32), .DIV2(24), .DIV3(16)) ksn_top_i (
      .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .return_lines(rl), .drive_lines(dl),
      .kbd_shift_value(kv), .kbd_clock_gate(gate), .nmi_req(nmi));
   ksn_kbd_model ksn_kbd_model_i (.ret_idx(ki), .ret_on(ron), .drv_idx(ki),
      .drv_on(don), .sv_in(sv), .return_lines(rl), .drive_lines(dl),
      .kbd_shift_value(kv));
   task automatic chk(input ksn_byte_t s, input ksn_byte_t e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic chk1(input logic s, input logic e);
      chk({7'h0, s}, {7'h0, e});
   endtask : chk1
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic put(input ksn_addr_t a, input ksn_byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : put
   task automatic get(input ksn_addr_t a, input ksn_byte_t e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : get
   task automatic wait_nmi(output int n);
      n = 0;
      while (nmi !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (nmi !== 1'b1) begin
         n_mismatch++;
         end_sim();
      end
   endtask : wait_nmi
   // Read results land one cycle after the strobe
   always @(posedge clk) rv <= rd;
   always @(negedge clk) if (rv) chk(rdata, q.pop_front());
   initial begin
      int n;
      int s;
      ksn_byte_t c;
      ksn_byte_t d;
      void'($urandom(32'h4678edf3));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      get(`KSN_IDX_SCAN_CFG, 8'h00);
      get(`KSN_IDX_NMI_CS, 8'h00);
      get(9'h0a0, 8'h00);
      for (s = 0; s < 4; s++) begin
         c = {4'($urandom), 1'b0, 1'($urandom), 2'(s)};
         put(`KSN_IDX_SCAN_CFG, c);
         get(`KSN_IDX_SCAN_CFG, c);
         put(`KSN_IDX_NMI_CS, 8'h40);
         put(`KSN_IDX_NMI_CS, 8'h04);
         wait_nmi(n);
         d = 8'(40 - 8 * s);
         chk1(n >= d - 2 && n <= d + 3, 1'b1);
         get(`KSN_IDX_NMI_CS, 8'h44);
         put(`KSN_IDX_NMI_CS, 8'h00);
         put(`KSN_IDX_NMI_CS, 8'h40);
         repeat (2) @(negedge clk);
         chk1(nmi, 1'b0);
      end
      repeat (60) @(negedge clk);
      chk1(nmi, 1'b0);
      for (s = 0; s < 2; s++) begin
         put(`KSN_IDX_SCAN_CFG, 8'(s << 2));
         put(`KSN_IDX_NMI_CS, 8'h08);
         ki <= 5'($urandom % 24);
         ron <= s[0];
         don <= !s[0];
         repeat (4) @(negedge clk);
         get(`KSN_IDX_NMI_CS, 8'h08);
         ron <= !s[0];
         don <= s[0];
         repeat (4) @(negedge clk);
         chk1(nmi, 1'b1);
         put(`KSN_IDX_NMI_CS, 8'h88);
         get(`KSN_IDX_NMI_CS, 8'h88);
         ron <= 1'b0;
         don <= 1'b0;
         put(`KSN_IDX_NMI_CS, 8'h00);
         put(`KSN_IDX_NMI_CS, 8'h80);
         ron <= !s[0];
         don <= s[0];
         get(`KSN_IDX_NMI_CS, 8'h00);
         ron <= 1'b0;
         don <= 1'b0;
         repeat (2) @(negedge clk);
         chk1(nmi, 1'b0);
      end
      put(`KSN_IO_CTRL_PORT, 8'h00);
      put(`KSN_IDX_NMI_CS, 8'h02);
      put(`KSN_IO_CTRL_PORT, 8'h40);
      repeat (2) @(negedge clk);
      chk1(gate, 1'b1);
      chk1(nmi, 1'b1);
      get(`KSN_IDX_NMI_CS, 8'h22);
      put(`KSN_IDX_NMI_CS, 8'h22);
      put(`KSN_IO_CTRL_PORT, 8'h40);
      repeat (3) @(negedge clk);
      chk1(nmi, 1'b0);
      @(posedge clk);
      sv <= 8'($urandom);
      d = 8'($urandom);
      put(`KSN_IO_DATA_PORT, d);
      get(`KSN_IO_DATA_PORT, sv);
      get(`KSN_IDX_SHADOW, d);
      put(`KSN_IDX_SCAN_CFG, 8'h08);
      put(`KSN_IO_DATA_PORT, ~d);
      get(`KSN_IO_DATA_PORT, ~d);
      get(`KSN_IDX_SHADOW, sv);
      repeat (3) @(posedge clk);
      end_sim();
   end
endmodule : tb
`default_nettype wire
